// File: rtl/rdc_pkg.sv
// constants, types and gain table for the redriver control register bank
//
// Function
// - inhibit clear: standby follows sink hot-plug; set: never auto standby
// - shutdown bit 0 forces shutdown; 1 lets the enable input decide
// - threshold field picks 40, 80, 160 or 250 mVpp, default 80
// - idle detection under chosen threshold drives output disable
// - idle detect bit is inverted: 0 enables detection, 1 disables it
// - training set follows training; clear uses registers, fixed equalizer
// - sideband code 00 joins sink and source sideband on cable detect
// - code 01 joins on cable detect and bypasses coupling caps in TMDS
// - code 10 joins on hot-plug and keeps the DDC source side off
// - equalizer bit 0 uses pins, 1 uses register fields, except a trained display sink at level 2 or 3 uses pins
// - level 0 field applies with registers, display sink, training, level 0
// - level 1 field applies with registers, display sink, training, level 1
// - level 1 field is also the fixed setting untrained or TMDS
// - three-bit codes map to gain per link rate, 000 is 0 dB
// - reserved bits read zero and ignore writes, except bit 3 at offset 04h, which is writable and reads back
// - reads start at offset 00h and advance byte by byte
// - target address is 01011 plus two bits from address select level
package rdc_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_RESERVED0 = 8'h00;
	localparam logic [7:0] OFS_POWER     = 8'h01;
	localparam logic [7:0] OFS_TRIAL     = 8'h02;
	localparam logic [7:0] OFS_IDLE      = 8'h03;
	localparam logic [7:0] OFS_TRAIN     = 8'h04;
	localparam logic [7:0] OFS_EQ0       = 8'h05;

	// ----------------------------------------
	// writable bit masks and reset values
	// ----------------------------------------
	localparam logic [7:0] MSK_POWER = 8'h03;
	localparam logic [7:0] MSK_TRIAL = 8'hff;
	localparam logic [7:0] MSK_IDLE  = 8'h38;
	localparam logic [7:0] MSK_TRAIN = 8'h0f;
	localparam logic [7:0] MSK_EQ0   = 8'hf7;
	localparam logic [7:0] RST_POWER = 8'h01;
	localparam logic [7:0] RST_TRIAL = 8'h00;
	localparam logic [7:0] RST_IDLE  = 8'h10;
	localparam logic [7:0] RST_TRAIN = 8'h04;
	localparam logic [7:0] RST_EQ0   = 8'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_SHUTDOWN_N  = 0;
	localparam int BIT_STBY_INHIB  = 1;
	localparam int BIT_IDLE_OFF    = 3;
	localparam int BIT_THR_LO      = 4;
	localparam int BIT_THR_HI      = 5;
	localparam int BIT_SB_LO       = 0;
	localparam int BIT_SB_HI       = 1;
	localparam int BIT_TRAIN_EN    = 2;
	localparam int BIT_EQ_FROM_REG = 7;
	localparam int BIT_L0_LO       = 4;
	localparam int BIT_L0_HI       = 6;
	localparam int BIT_L1_LO       = 0;
	localparam int BIT_L1_HI       = 2;

	// ----------------------------------------
	// sideband codes and target address
	// ----------------------------------------
	localparam logic [1:0] SB_DDC_CABLE  = 2'h0;
	localparam logic [1:0] SB_CAP_BYPASS = 2'h1;
	localparam logic [1:0] SB_HOTPLUG    = 2'h2;
	localparam logic [4:0] ADDR_UPPER    = 5'h0b;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------
	// threshold in mVpp per code
	// ----------------------------------------
	localparam logic [7:0] THR_MV_0 = 8'd40;
	localparam logic [7:0] THR_MV_1 = 8'd80;
	localparam logic [7:0] THR_MV_2 = 8'd160;
	localparam logic [7:0] THR_MV_3 = 8'd250;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
		ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_WAIT
	} rdc_state_t;

	// gain in tenths of dB; doubled selects the higher link rate
	function automatic logic [7:0] rdc_gain(input logic [2:0] code,
	                                        input logic       doubled);
		logic [7:0] g;
		g = 8'h00;
		case (code)
			3'h0: g = 8'd0;
			3'h1: g = doubled ? 8'd35 : 8'd15;
			3'h2: g = doubled ? 8'd60 : 8'd30;
			3'h3: g = doubled ? 8'd80 : 8'd40;
			3'h4: g = doubled ? 8'd100 : 8'd50;
			3'h5: g = doubled ? 8'd130 : 8'd60;
			3'h6: g = doubled ? 8'd150 : 8'd70;
			default: g = doubled ? 8'd180 : 8'd90;
		endcase
		return g;
	endfunction

endpackage

// File: rtl/rdc_eq_select.sv
// lane 0 equalizer source selection and gain lookup
module rdc_eq_select
	import rdc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_sync_n,
	input  wire logic       eq_from_registers,
	input  wire logic [2:0] lane0_gain_level0,
	input  wire logic [2:0] lane0_gain_level1,
	input  wire logic [2:0] eq_pin_code,
	input  wire logic       tmds_sink_sel,
	input  wire logic       training_enabled,
	input  wire logic [1:0] trained_preemph,
	input  wire logic       rate_doubled,
	output logic      [2:0] eq_code,
	output logic      [7:0] eq_gain_x10
);

	logic [2:0] next_eq_code;

	// ----------------------------------------
	// source selection
	// ----------------------------------------
	always_comb begin
		next_eq_code = eq_pin_code;
		if (eq_from_registers) begin
			if (tmds_sink_sel || !training_enabled) begin
				next_eq_code = lane0_gain_level1;
			end else if (trained_preemph == 2'h0) begin
				next_eq_code = lane0_gain_level0;
			end else if (trained_preemph == 2'h1) begin
				next_eq_code = lane0_gain_level1;
			end else begin
				next_eq_code = eq_pin_code;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			eq_code     <= 3'h0;
			eq_gain_x10 <= 8'h00;
		end else begin
			eq_code     <= next_eq_code;
			eq_gain_x10 <= rdc_gain(next_eq_code, rate_doubled);
		end
	end

endmodule

// File: rtl/rdc_top.sv
// redriver control register bank with its two-wire target port
module rdc_top
	import rdc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [1:0] address_select_pin,
	input  wire logic       enable_in,
	input  wire logic       sink_hotplug_in,
	input  wire logic       sink_cable_detect,
	input  wire logic       lane0_idle_in,
	input  wire logic       tmds_sink_sel,
	input  wire logic [1:0] trained_preemph,
	input  wire logic       rate_doubled,
	input  wire logic [2:0] eq_pin_code,
	output logic            shutdown_req,
	output logic            standby_req,
	output logic      [1:0] idle_threshold_code,
	output logic      [7:0] idle_threshold_mv,
	output logic            output_disable_req,
	output logic            follow_training,
	output logic            eq_hold,
	output logic            sideband_connect,
	output logic            ddc_source_enable,
	output logic            cap_bypass,
	output logic      [2:0] eq_code,
	output logic      [7:0] eq_gain_x10
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta_n;
	logic rst_sync_n;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ----------------------------------------
	// bus edge detection
	// ----------------------------------------
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	assign scl_rise  = scl_in && !scl_q;
	assign scl_fall  = !scl_in && scl_q;
	assign bus_start = scl_in && scl_q && sda_q && !sda_in;
	assign bus_stop  = scl_in && scl_q && !sda_q && sda_in;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] power_state_control;
	logic [7:0] factory_trial_byte;
	logic [7:0] idle_detect_control;
	logic [7:0] training_sideband_control;
	logic [7:0] lane0_equalizer_low_levels;
	logic [7:0] ptr;
	logic [7:0] shreg;
	logic       wr_stb;
	logic [7:0] rd_data;
	logic [7:0] rd_ofs;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			power_state_control        <= RST_POWER;
			factory_trial_byte         <= RST_TRIAL;
			idle_detect_control        <= RST_IDLE;
			training_sideband_control  <= RST_TRAIN;
			lane0_equalizer_low_levels <= RST_EQ0;
		end else if (wr_stb) begin
			case (ptr)
				OFS_POWER: power_state_control <= shreg & MSK_POWER;
				OFS_TRIAL: factory_trial_byte  <= shreg & MSK_TRIAL;
				OFS_IDLE:  idle_detect_control <= shreg & MSK_IDLE;
				OFS_TRAIN: training_sideband_control <= shreg & MSK_TRAIN;
				OFS_EQ0:   lane0_equalizer_low_levels <= shreg & MSK_EQ0;
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_data = 8'h00;
		case (rd_ofs)
			OFS_POWER: rd_data = power_state_control;
			OFS_TRIAL: rd_data = factory_trial_byte;
			OFS_IDLE:  rd_data = idle_detect_control;
			OFS_TRAIN: rd_data = training_sideband_control;
			OFS_EQ0:   rd_data = lane0_equalizer_low_levels;
			default:   rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------
	// target port state machine
	// ----------------------------------------
	rdc_state_t state;
	logic [3:0] bit_cnt;
	logic       rd_mode;
	logic       host_nack;
	logic       addr_match;
	logic [6:0] own_addr;

	assign own_addr   = {ADDR_UPPER, address_select_pin};
	assign addr_match = (shreg[7:1] == own_addr);
	assign rd_ofs     = (state == ST_RACK) ? ptr + 8'h01 : OFS_RESERVED0;
	assign wr_stb     = (state == ST_WDATA) && scl_fall
	                    && (bit_cnt == BITS_PER_BYTE);

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state     <= ST_IDLE;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			rd_mode   <= 1'b0;
			host_nack <= 1'b0;
			ptr       <= 8'h00;
		end else if (bus_start) begin
			state   <= ST_ADDR;
			bit_cnt <= 4'h0;
		end else if (bus_stop) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_ADDR, ST_SUB, ST_WDATA: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], sda_in};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
						bit_cnt <= 4'h0;
						if (state == ST_ADDR) begin
							rd_mode <= shreg[0];
							state   <= addr_match ? ST_ADDR_ACK : ST_WAIT;
						end else if (state == ST_SUB) begin
							ptr   <= shreg;
							state <= ST_SUB_ACK;
						end else begin
							state <= ST_WACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (rd_mode) begin
							ptr   <= 8'h00;
							shreg <= rd_data;
							state <= ST_RDATA;
						end else begin
							state <= ST_SUB;
						end
					end
				end
				ST_SUB_ACK: begin
					if (scl_fall) begin
						state <= ST_WDATA;
					end
				end
				ST_WACK: begin
					if (scl_fall) begin
						ptr   <= ptr + 8'h01;
						state <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == BITS_PER_BYTE) begin
							bit_cnt <= 4'h0;
							state   <= ST_RACK;
						end else begin
							shreg <= {shreg[6:0], 1'b0};
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						host_nack <= sda_in;
					end else if (scl_fall) begin
						if (host_nack) begin
							state <= ST_WAIT;
						end else begin
							ptr   <= ptr + 8'h01;
							shreg <= rd_data;
							state <= ST_RDATA;
						end
					end
				end
				ST_IDLE, ST_WAIT: ;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// data pin drive
	// ----------------------------------------
	logic next_sda_oe;

	always_comb begin
		case (state)
			ST_ADDR_ACK, ST_SUB_ACK, ST_WACK: next_sda_oe = 1'b1;
			ST_RDATA: next_sda_oe = !shreg[7];
			default:  next_sda_oe = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sda_oe <= 1'b0;
		end else begin
			sda_oe <= next_sda_oe;
		end
	end

	assign sda_out = 1'b0;

	// ----------------------------------------
	// control outputs
	// ----------------------------------------
	logic [1:0] sb_cfg;
	logic       idle_on;

	assign sb_cfg  = training_sideband_control[BIT_SB_HI:BIT_SB_LO];
	assign idle_on = !idle_detect_control[BIT_IDLE_OFF];

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			shutdown_req        <= 1'b1;
			standby_req         <= 1'b0;
			idle_threshold_code <= 2'h0;
			idle_threshold_mv   <= 8'h00;
			output_disable_req  <= 1'b0;
			follow_training     <= 1'b0;
			eq_hold             <= 1'b0;
		end else begin
			shutdown_req <= !power_state_control[BIT_SHUTDOWN_N]
			                || !enable_in;
			standby_req  <= !power_state_control[BIT_STBY_INHIB]
			                && !sink_hotplug_in;
			idle_threshold_code <=
				idle_detect_control[BIT_THR_HI:BIT_THR_LO];
			case (idle_detect_control[BIT_THR_HI:BIT_THR_LO])
				2'h0:    idle_threshold_mv <= THR_MV_0;
				2'h1:    idle_threshold_mv <= THR_MV_1;
				2'h2:    idle_threshold_mv <= THR_MV_2;
				default: idle_threshold_mv <= THR_MV_3;
			endcase
			output_disable_req <= idle_on && lane0_idle_in;
			follow_training <= training_sideband_control[BIT_TRAIN_EN];
			eq_hold         <= !training_sideband_control[BIT_TRAIN_EN];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sideband_connect  <= 1'b0;
			ddc_source_enable <= 1'b0;
			cap_bypass        <= 1'b0;
		end else begin
			sideband_connect  <= 1'b0;
			ddc_source_enable <= 1'b0;
			cap_bypass        <= 1'b0;
			case (sb_cfg)
				SB_DDC_CABLE: begin
					sideband_connect  <= sink_cable_detect;
					ddc_source_enable <= sink_cable_detect;
				end
				SB_CAP_BYPASS: begin
					sideband_connect <= sink_cable_detect;
					cap_bypass       <= sink_cable_detect && tmds_sink_sel;
				end
				SB_HOTPLUG: sideband_connect <= sink_hotplug_in;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// equalizer
	// ----------------------------------------
	rdc_eq_select u_eq (
		.clk_sys           (clk_sys),
		.rst_sync_n        (rst_sync_n),
		.eq_from_registers (lane0_equalizer_low_levels[BIT_EQ_FROM_REG]),
		.lane0_gain_level0 (lane0_equalizer_low_levels[BIT_L0_HI:BIT_L0_LO]),
		.lane0_gain_level1 (lane0_equalizer_low_levels[BIT_L1_HI:BIT_L1_LO]),
		.eq_pin_code       (eq_pin_code),
		.tmds_sink_sel     (tmds_sink_sel),
		.training_enabled  (training_sideband_control[BIT_TRAIN_EN]),
		.trained_preemph   (trained_preemph),
		.rate_doubled      (rate_doubled),
		.eq_code           (eq_code),
		.eq_gain_x10       (eq_gain_x10)
	);

endmodule

// File: bench/rdc_top_asserts.sv
// port checker for the redriver control register bank
module rdc_top_asserts
	import rdc_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       scl_in,
	input wire logic       sda_oe,
	input wire logic       enable_in,
	input wire logic       sink_hotplug_in,
	input wire logic       sink_cable_detect,
	input wire logic       lane0_idle_in,
	input wire logic       tmds_sink_sel,
	input wire logic       shutdown_req,
	input wire logic       standby_req,
	input wire logic [1:0] idle_threshold_code,
	input wire logic [7:0] idle_threshold_mv,
	input wire logic       output_disable_req,
	input wire logic       follow_training,
	input wire logic       eq_hold,
	input wire logic       sideband_connect,
	input wire logic       ddc_source_enable,
	input wire logic       cap_bypass
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ----------
	// outputs settle a few clocks after reset release
	// ----------
	logic [2:0] age;
	wire        live = (age == 3'h4);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			age <= 3'h0;
		end else if (age != 3'h4) begin
			age <= age + 3'h1;
		end
	end
	a_shutdown_enable: assert property (
		live && $fell(enable_in) |-> ##[1:2] shutdown_req)
		else $error("shutdown not raised after enable fell");
	a_standby_hotplug: assert property (
		live && $past(sink_hotplug_in) |-> !standby_req)
		else $error("standby requested with hot-plug high");
	a_idle_cause: assert property (
		output_disable_req |-> $past(lane0_idle_in))
		else $error("output disable without idle input");
	a_threshold_map: assert property (
		live |-> idle_threshold_mv == (idle_threshold_code == 2'h0 ? THR_MV_0 :
			idle_threshold_code == 2'h1 ? THR_MV_1 :
			idle_threshold_code == 2'h2 ? THR_MV_2 : THR_MV_3))
		else $error("threshold value does not match its code");
	a_training_hold: assert property (
		live |-> eq_hold == !follow_training)
		else $error("equalizer hold not opposite to training follow");
	a_ddc_cable: assert property (
		ddc_source_enable |-> sideband_connect && !cap_bypass &&
			$past(sink_cable_detect))
		else $error("source side enabled without cable detect");
	a_bypass_cause: assert property (
		cap_bypass |-> sideband_connect && $past(sink_cable_detect) &&
			$past(tmds_sink_sel))
		else $error("coupling bypass without cable and tmds sink");
	a_hotplug_path: assert property (
		sideband_connect && !$past(sink_cable_detect) |->
			$past(sink_hotplug_in) && !ddc_source_enable)
		else $error("sideband joined without cable or hot-plug");
	a_data_steady: assert property (
		$changed(sda_oe) |-> !scl_in)
		else $error("data line moved while clock high");
	cover property (cap_bypass);
	cover property (output_disable_req);
	cover property ($rose(sda_oe));
	cover property (live && standby_req);
endmodule

bind rdc_top rdc_top_asserts chk_u (
	.clk_sys, .rst_n, .scl_in, .sda_oe, .enable_in, .sink_hotplug_in,
	.sink_cable_detect, .lane0_idle_in, .tmds_sink_sel, .shutdown_req,
	.standby_req, .idle_threshold_code, .idle_threshold_mv,
	.output_disable_req, .follow_training, .eq_hold, .sideband_connect,
	.ddc_source_enable, .cap_bypass
);

// File: bench/rdc_host_model.sv
// two-wire host model that programs and reads the register bank
module rdc_host_model (
	input  wire logic clk_sys,
	input  wire logic sda_wire,
	output logic      scl_drv,
	output logic      sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end
	// one bus phase, longer than the two clocks the port needs
	task automatic put(input logic s, input logic d);
		scl_drv <= s;
		sda_drv <= d;
		repeat (5) @(posedge clk_sys);
	endtask
	task automatic wbit(input logic b);
		put(1'b0, b);
		put(1'b1, b);
		put(1'b0, b);
	endtask
	task automatic rbit(output logic b);
		put(1'b0, 1'b1);
		put(1'b1, 1'b1);
		b = sda_wire;
		put(1'b0, 1'b1);
	endtask
	task automatic stop();
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ak);
		logic b;
		for (int i = 7; i >= 0; i--) wbit(d[i]);
		rbit(b);
		ak = !b;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) rbit(d[i]);
		wbit(last);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] o,
	                  input logic [7:0] d, output logic ak);
		logic k1, k2, k3;
		put(1'b1, 1'b1);
		put(1'b1, 1'b0);
		wbyte({a, 1'b0}, k1);
		wbyte(o, k2);
		wbyte(d, k3);
		stop();
		ak = k1 & k2 & k3;
	endtask
	task automatic rd(input logic [6:0] a, input int n,
	                  output logic [7:0] q [8]);
		logic k;
		put(1'b1, 1'b1);
		put(1'b1, 1'b0);
		wbyte({a, 1'b1}, k);
		for (int i = 0; i < n; i++) rbyte(i == n - 1, q[i]);
		stop();
	endtask
endmodule

// File: bench/tb.sv
// self-checking bench for the redriver control register bank
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// offset, write data, readback, watched outputs
	typedef logic [31:0] rdc_row_t;
	logic       clk_sys, rst_n, enable_in, sink_hotplug_in, sink_cable_detect;
	logic       lane0_idle_in, tmds_sink_sel, rate_doubled, scl_drv, sda_drv;
	logic       sda_out, sda_oe, shutdown_req, standby_req, output_disable_req;
	logic       follow_training, eq_hold, sideband_connect, ddc_source_enable;
	logic       cap_bypass, ack;
	logic [1:0] address_select_pin, trained_preemph, idle_threshold_code;
	logic [2:0] eq_pin_code, eq_code;
	logic [7:0] idle_threshold_mv, eq_gain_x10;
	logic [7:0] q [8];
	wire        sda_wire = sda_drv & ~sda_oe;
	int         failures, total_checks, cycles;
	rdc_row_t   rows [15];
	rdc_top dut_u (
		.clk_sys, .rst_n, .scl_in(scl_drv), .sda_in(sda_wire), .sda_out,
		.sda_oe, .address_select_pin, .enable_in, .sink_hotplug_in,
		.sink_cable_detect, .lane0_idle_in, .tmds_sink_sel, .trained_preemph,
		.rate_doubled, .eq_pin_code, .shutdown_req, .standby_req,
		.idle_threshold_code, .idle_threshold_mv, .output_disable_req,
		.follow_training, .eq_hold, .sideband_connect, .ddc_source_enable,
		.cap_bypass, .eq_code, .eq_gain_x10
	);
	rdc_host_model host_u (.clk_sys, .sda_wire, .scl_drv, .sda_drv);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			give_verdict();
		end
	end
	// ----------
	// helpers
	// ----------
	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic settle();
		repeat (4) @(posedge clk_sys);
	endtask
	function automatic logic [7:0] mon(input logic [7:0] ofs);
		case (ofs)
			8'h01: return {6'h00, shutdown_req, standby_req};
			8'h03: return idle_threshold_mv;
			8'h04: return {4'h0, follow_training, sideband_connect,
				ddc_source_enable, cap_bypass};
			default: return {5'h00, eq_code};
		endcase
	endfunction
	task automatic reset_check();
		logic [7:0] r [6] = '{8'h00, 8'h01, 8'h00, 8'h10, 8'h04, 8'h00};
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("shutdown in reset", 8'h01, {7'h00, shutdown_req});
		chk("data drive in reset", 8'h00, {7'h00, sda_oe});
		chk("data level", 8'h00, {7'h00, sda_out});
		rst_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		host_u.rd(7'h2c, 6, q);
		foreach (r[i]) chk("reset value", r[i], q[i]);
	endtask
	// ----------
	// main sequence
	// ----------
	initial begin
		rst_n = 1'b0;
		enable_in = 1'b1;
		sink_hotplug_in = 1'b0;
		sink_cable_detect = 1'b1;
		lane0_idle_in = 1'b1;
		tmds_sink_sel = 1'b1;
		rate_doubled = 1'b0;
		address_select_pin = 2'h0;
		trained_preemph = 2'h0;
		eq_pin_code = 3'h5;
		rows = '{
			32'h00aa0005,
			32'h01000003,
			32'h01fe0202,
			32'h01030300,
			32'h03000028,
			32'h03101050,
			32'h03e020a0,
			32'h033838fa,
			32'h0404040e,
			32'h04010105,
			32'h04060608,
			32'h05000005,
			32'h05838303,
			32'h05fff707,
			32'h02000007
		};
		reset_check();
		foreach (rows[i]) begin
			host_u.wr(7'h2c, rows[i][31:24], rows[i][23:16], ack);
			chk("write ack", 8'h01, {7'h00, ack});
			host_u.rd(7'h2c, rows[i][31:24] + 1, q);
			chk("readback", rows[i][15:8], q[rows[i][26:24]]);
			chk("outputs", rows[i][7:0], mon(rows[i][31:24]));
		end
		chk("threshold code", 8'h03, {6'h00, idle_threshold_code});
		for (int s = 0; s < 3; s++) begin
			address_select_pin <= s[1:0];
			settle();
			host_u.wr({5'h0b, s[1:0]}, 8'h05, 8'hb2, ack);
			chk("address ack", 8'h01, {7'h00, ack});
			host_u.wr({5'h0b, 2'h3 - s[1:0]}, 8'h05, 8'h00, ack);
			chk("foreign address", 8'h00, {7'h00, ack});
		end
		host_u.rd(7'h2e, 6, q);
		chk("refused write", 8'hb2, q[5]);
		address_select_pin <= 2'h0;
		sink_hotplug_in <= 1'b1;
		sink_cable_detect <= 1'b0;
		settle();
		chk("hotplug path", 8'h0c, mon(8'h04));
		host_u.wr(7'h2c, 8'h01, 8'h01, ack);
		chk("standby with hotplug", 8'h00, mon(8'h01));
		chk("idle detect off", 8'h00, {7'h00, output_disable_req});
		host_u.wr(7'h2c, 8'h03, 8'h00, ack);
		chk("idle detect on", 8'h01, {7'h00, output_disable_req});
		lane0_idle_in <= 1'b0;
		settle();
		chk("active stream", 8'h00, {7'h00, output_disable_req});
		host_u.wr(7'h2c, 8'h04, 8'h04, ack);
		tmds_sink_sel <= 1'b0;
		rate_doubled <= 1'b1;
		settle();
		chk("level 0 code", 8'h03, {5'h00, eq_code});
		chk("doubled gain", 8'h50, eq_gain_x10);
		trained_preemph <= 2'h1;
		rate_doubled <= 1'b0;
		settle();
		chk("level 1 code", 8'h02, {5'h00, eq_code});
		chk("standard gain", 8'h1e, eq_gain_x10);
		host_u.wr(7'h2c, 8'h04, 8'h00, ack);
		trained_preemph <= 2'h0;
		settle();
		chk("untrained code", 8'h02, {5'h00, eq_code});
		chk("held equalizer", 8'h01, {7'h00, eq_hold});
		enable_in <= 1'b0;
		settle();
		chk("enable low", 8'h02, mon(8'h01));
		enable_in <= 1'b1;
		reset_check();
		give_verdict();
	end
endmodule
